// ==== rtl/orc_axil_slave.sv ====
`timescale 1ns/1ns
module orc_axil_slave
  import orc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset
  input orc_axi_req_t req, // Bus request
  output orc_axi_rsp_t rsp, // Bus response, registered
  output logic wrEn, // Write strobe
  input wire logic wrErr, // Write address unmapped
  input wire logic [31:0] rdData, // Read data for araddr
  input wire logic rdErr // Read address unmapped
);

  orc_axi_rsp_t rsp_q;

  assign rsp = rsp_q;
  assign wrEn = req.awvalid & req.wvalid & rsp_q.awready;

  // --------------------------------------------------------------
  // Write channel: both taken together, response after
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_q.awready <= 1'b0;
      rsp_q.wready <= 1'b0;
      rsp_q.bvalid <= 1'b0;
      rsp_q.bresp <= RESP_OKAY;
    end else if (wrEn) begin
      rsp_q.awready <= 1'b0;
      rsp_q.wready <= 1'b0;
      rsp_q.bvalid <= 1'b1;
      rsp_q.bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
    end else if (rsp_q.bvalid) begin
      if (req.bready) begin
        rsp_q.bvalid <= 1'b0;
      end
    end else begin
      rsp_q.awready <= req.awvalid & req.wvalid;
      rsp_q.wready <= req.awvalid & req.wvalid;
    end
  end

  // --------------------------------------------------------------
  // Read channel: data captured at address handshake
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_q.arready <= 1'b0;
      rsp_q.rvalid <= 1'b0;
      rsp_q.rdata <= 32'h0000_0000;
      rsp_q.rresp <= RESP_OKAY;
    end else if (req.arvalid & rsp_q.arready) begin
      rsp_q.arready <= 1'b0;
      rsp_q.rvalid <= 1'b1;
      rsp_q.rdata <= rdData;
      rsp_q.rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
    end else if (rsp_q.rvalid) begin
      if (req.rready) begin
        rsp_q.rvalid <= 1'b0;
      end
    end else begin
      rsp_q.arready <= req.arvalid;
    end
  end

endmodule // orc_axil_slave

// ==== rtl/orc_homing_setup.sv ====
`timescale 1ns/1ns
// Functional notes
// - Mode 6: limit stop, reverse at speed A, index count stop; reset at release.
// - Mode 7: limit stop, reverse at speed A, count index after release; reset at stop.
// - Mode 8: as mode 7 but immediate stop at limit and reverse at speed L; reset at count end.
// - Mode 9: homing operation 0, then move until mechanical count is zero.
// - Mode 10: homing operation 3, then move back to mechanical count zero.
// - Mode 11: homing operation 5, then drive to mechanical count zero.
// - Mode 12: homing operation 8, then move to mechanical count zero.
// - Bits 4-7 give index pulses to count; 0 means first, 15 sixteenth.
// - Bits 8-9 pick mechanical count source: encoder, output pulses, pulser.
// - Bits 10-11 pick deflection pair: out/enc, out/pulser, enc/pulser.
// - Bits 12-13 pick general source: out, encoder, pulser, clock over two.
// - Bit 14 lets general count only while busy output is low.
// - Bits 16-19 let clear input reset counters one to four.
// - Bits 20-23 reset each of the four counters at the reset point of the mode.
// - Bits 24-27 let each counter count correction pulses; zero excludes them.
// - Bits 29-31 halt mechanical, deflection and general counters.
// - Operation 3: count index after origin; stop, or decelerate at high speed.
// - Operation 5: origin stop, reverse, count index after release, then stop.
module orc_homing_setup
  import orc_pkg::*;
(
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst, // Async reset, active high
  input orc_axi_req_t axiReq, // AXI4-Lite request
  output orc_axi_rsp_t axiRsp, // AXI4-Lite response
  input wire logic endLimitInput, // End limit sensor
  input wire logic originSensorInput, // Origin sensor
  input wire logic encoderIndexInput, // Index pulse, one cycle
  input wire logic highSpeedFeed, // Feeding at high speed
  input wire logic motorStopped, // Axis has stopped
  input wire logic axisOperating, // Other motion in progress
  input wire logic backlashActive, // Correction pulses being output
  input wire logic count1Halt, // Operation mode halt bit
  input wire logic counterClearInput, // Counter clear level
  input orc_step_t outputPulse, // Output pulse step
  input orc_step_t encoderPhase, // Encoder phase step
  input orc_step_t pulserPhase, // Pulser phase step
  output logic feedRun, // Feed command
  output logic feedDir, // Feed direction, 1 = positive
  output logic [1:0] feedSpeed, // Feed speed select
  output logic stopNow, // Immediate stop pulse
  output logic decelStop, // Deceleration stop pulse
  output logic homeDone, // Homing complete level
  output logic motionActiveN // Busy, active low
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] baseMode(input logic [3:0] m);
    case (m)
      MODE_9: baseMode = MODE_0;
      MODE_10: baseMode = MODE_3;
      MODE_11: baseMode = MODE_5;
      MODE_12: baseMode = MODE_8;
      default: baseMode = m;
    endcase
  endfunction

  function automatic orc_step_t pickStep(input logic [1:0] sel,
      input orc_step_t s0, input orc_step_t s1, input orc_step_t s2);
    case (sel)
      2'h0: pickStep = s0;
      2'h1: pickStep = s1;
      2'h2: pickStep = s2;
      default: pickStep = '0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= ADDR_CNT4) && (a[1:0] == 2'h0);
  endfunction

  // ---------------------------------------------------------------
  // Registers and signals
  // ---------------------------------------------------------------
  logic [31:0] setup_q;
  logic startDir_q;
  orc_state_t state_q;
  logic [3:0] idxCnt_q;
  logic [3:0] runMode_q;
  logic homeRst_q;
  logic clearPrev_q;
  logic clkHalf_q;
  logic wrEn;
  logic startReq;
  logic [31:0] rdData;
  logic clearEdge;
  logic sensor;
  logic [3:0] base;
  logic retMode;
  logic lastIdx;
  logic [CNT_W-1:0] cnt [4];
  logic [3:0] cntClr;
  logic [3:0] cntEn;
  orc_step_t outGated [4];
  orc_step_t addSel [4];
  orc_step_t subSel [4];
  logic [3:0] homeRstEn;
  logic [3:0] clearEn;

  assign homeRstEn = setup_q[HOME_RST_LSB +: 4];
  assign clearEn = setup_q[CLEAR_EN_LSB +: 4];
  assign base = baseMode(runMode_q);
  assign retMode = (runMode_q >= MODE_9) && (runMode_q <= MODE_12);
  assign sensor = (base >= MODE_6) ? endLimitInput : originSensorInput;
  assign lastIdx = encoderIndexInput
                   && (idxCnt_q == setup_q[IDX_LSB +: 4]);
  assign clearEdge = counterClearInput & ~clearPrev_q;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  orc_axil_slave u_slave (
    .clk(clk),
    .rst(rst),
    .req(axiReq),
    .rsp(axiRsp),
    .wrEn(wrEn),
    .wrErr(~mapped(axiReq.awaddr)),
    .rdData(rdData),
    .rdErr(~mapped(axiReq.araddr))
  );

  assign startReq = wrEn && (axiReq.awaddr == ADDR_CTRL)
                    && axiReq.wstrb[0] && axiReq.wdata[CTRL_START_BIT];

  // Setup register, byte lanes, undefined bits kept zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setup_q <= SETUP_RESET;
    end else if (wrEn && axiReq.awaddr == ADDR_SETUP) begin
      for (int b = 0; b < 4; b++) begin
        if (axiReq.wstrb[b]) begin
          setup_q[8*b +: 8] <= axiReq.wdata[8*b +: 8]
                               & SETUP_WMASK[8*b +: 8];
        end
      end
    end
  end

  // Start direction held in control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startDir_q <= 1'b0;
    end else if (wrEn && axiReq.awaddr == ADDR_CTRL && axiReq.wstrb[0]) begin
      startDir_q <= axiReq.wdata[CTRL_DIR_BIT];
    end
  end

  // Read multiplexer
  always_comb begin
    case (axiReq.araddr)
      ADDR_SETUP: rdData = setup_q;
      ADDR_CTRL: rdData = {30'h0, startDir_q, 1'b0};
      ADDR_STATUS: rdData = {16'h0, 4'h0, idxCnt_q, homeDone, state_q};
      ADDR_CNT1: rdData = cnt[0];
      ADDR_CNT2: rdData = cnt[1];
      ADDR_CNT3: rdData = cnt[2];
      ADDR_CNT4: rdData = cnt[3];
      default: rdData = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Homing sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      runMode_q <= MODE_0;
      idxCnt_q <= 4'h0;
      feedRun <= 1'b0;
      feedDir <= 1'b0;
      feedSpeed <= SPEED_NORMAL;
      stopNow <= 1'b0;
      decelStop <= 1'b0;
      homeRst_q <= 1'b0;
      homeDone <= 1'b0;
    end else begin
      stopNow <= 1'b0;
      decelStop <= 1'b0;
      homeRst_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (startReq) begin
            runMode_q <= setup_q[MODE_LSB +: 4];
            feedRun <= 1'b1;
            feedDir <= axiReq.wdata[CTRL_DIR_BIT];
            feedSpeed <= SPEED_NORMAL;
            homeDone <= 1'b0;
            state_q <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          if (sensor) begin
            idxCnt_q <= 4'h0;
            if (base == MODE_3) begin
              // Keep feeding; the kind of stop is chosen at count end
              state_q <= ST_COUNT;
            end else begin
              feedRun <= 1'b0;
              if (base >= MODE_6) begin
                decelStop <= setup_q[MODE_LSB];
                stopNow <= ~setup_q[MODE_LSB];
              end else begin
                decelStop <= highSpeedFeed;
                stopNow <= ~highSpeedFeed;
              end
              homeRst_q <= (base == MODE_0);
              state_q <= (base == MODE_0) ? ST_FINISH : ST_HALT;
            end
          end
        end
        ST_HALT: begin
          if (motorStopped) begin
            feedRun <= 1'b1;
            feedDir <= ~feedDir;
            feedSpeed <= (base == MODE_8) ? SPEED_RFL : SPEED_RFA;
            state_q <= ST_REVERSE;
          end
        end
        ST_REVERSE: begin
          if (!sensor) begin
            homeRst_q <= (base == MODE_6);
            state_q <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (lastIdx) begin
            feedRun <= 1'b0;
            if (base == MODE_3 || base == MODE_5) begin
              decelStop <= highSpeedFeed;
              stopNow <= ~highSpeedFeed;
            end else begin
              stopNow <= 1'b1;
            end
            homeRst_q <= (base != MODE_6);
            state_q <= ST_FINISH;
          end else if (encoderIndexInput) begin
            idxCnt_q <= idxCnt_q + 4'h1;
          end
        end
        ST_FINISH: begin
          if (motorStopped) begin
            if (retMode && cnt[1] != '0) begin
              feedRun <= 1'b1;
              feedDir <= cnt[1][CNT_W-1];
              feedSpeed <= SPEED_NORMAL;
              state_q <= ST_ZERO;
            end else begin
              homeDone <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ZERO: begin
          if (cnt[1] == '0) begin
            feedRun <= 1'b0;
            stopNow <= 1'b1;
            state_q <= ST_FINISH;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Busy output and clear edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motionActiveN <= 1'b1;
      clearPrev_q <= 1'b0;
      clkHalf_q <= 1'b0;
    end else begin
      motionActiveN <= ~(axisOperating | (state_q != ST_IDLE) | startReq);
      clearPrev_q <= counterClearInput;
      clkHalf_q <= ~clkHalf_q;
    end
  end

  // ---------------------------------------------------------------
  // Counter sources, gating and clears
  // ---------------------------------------------------------------
  assign addSel[0] = outGated[0];
  assign subSel[0] = '0;
  assign addSel[1] = pickStep(setup_q[MECH_SRC_LSB +: 2], encoderPhase,
                              outGated[1], pulserPhase);
  assign subSel[1] = '0;
  assign addSel[2] = pickStep(setup_q[DEFL_SRC_LSB +: 2], outGated[2],
                              outGated[2], encoderPhase);
  assign subSel[2] = pickStep(setup_q[DEFL_SRC_LSB +: 2], encoderPhase,
                              pulserPhase, pulserPhase);
  assign addSel[3] = (setup_q[GEN_SRC_LSB +: 2] == 2'h3)
                     ? orc_step_t'{pulse: clkHalf_q, up: 1'b1}
                     : pickStep(setup_q[GEN_SRC_LSB +: 2], outGated[3],
                                encoderPhase, pulserPhase);
  assign subSel[3] = '0;
  assign cntEn[0] = ~count1Halt;
  assign cntEn[1] = ~setup_q[HALT2_BIT];
  assign cntEn[2] = ~setup_q[HALT3_BIT];
  assign cntEn[3] = ~setup_q[HALT4_BIT]
                    & (~setup_q[BUSY_GATE_BIT] | ~motionActiveN);

  generate
    for (genvar k = 0; k < 4; k++) begin : g_cnt
      // Correction pulses counted only when allowed
      assign outGated[k] = '{pulse: outputPulse.pulse
          & (~backlashActive | setup_q[BACKLASH_LSB + k]),
          up: outputPulse.up};
      assign cntClr[k] = (clearEdge & clearEn[k])
                         | (homeRst_q & homeRstEn[k]);
      orc_step_counter u_cnt (
        .clk(clk),
        .rst(rst),
        .clr(cntClr[k]),
        .en(cntEn[k]),
        .addStep(addSel[k]),
        .subStep(subSel[k]),
        .count(cnt[k])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_undef_zero;
    setup_q[15] == 1'b0 && setup_q[28] == 1'b0;
  endproperty
  a_undef_zero: assert property (p_undef_zero)
    else $error("undefined setup bits not zero");

  property p_clear_c1;
    clearEdge && setup_q[CLEAR_EN_LSB] |=> cnt[0] == '0;
  endproperty
  a_clear_c1: assert property (p_clear_c1)
    else $error("clear input did not reset counter one");

  property p_halt2;
    setup_q[HALT2_BIT] && !cntClr[1] |=> $stable(cnt[1]);
  endproperty
  a_halt2: assert property (p_halt2)
    else $error("halted mechanical counter moved");

  property p_busy_gate;
    setup_q[BUSY_GATE_BIT] && motionActiveN && !cntClr[3]
      |=> $stable(cnt[3]);
  endproperty
  a_busy_gate: assert property (p_busy_gate)
    else $error("general counter moved while idle");

  property p_home_rst;
    homeRst_q && homeRstEn[3] |=> cnt[3] == '0;
  endproperty
  a_home_rst: assert property (p_home_rst)
    else $error("home reset missed general counter");

  property p_mode6_rst;
    state_q == ST_REVERSE && base == MODE_6 && !sensor
      |=> homeRst_q && state_q == ST_COUNT;
  endproperty
  a_mode6_rst: assert property (p_mode6_rst)
    else $error("mode 6 reset not at limit release");

  property p_idx_stop;
    state_q == ST_COUNT && lastIdx |=> !feedRun && state_q == ST_FINISH
      && (stopNow || decelStop);
  endproperty
  a_idx_stop: assert property (p_idx_stop)
    else $error("index count end did not stop axis");

  property p_rfl;
    state_q == ST_HALT && base == MODE_8 && motorStopped
      |=> feedSpeed == SPEED_RFL && feedRun;
  endproperty
  a_rfl: assert property (p_rfl)
    else $error("mode 8 reverse not at speed L");

  property p_zero_stop;
    state_q == ST_ZERO && cnt[1] == '0 |=> !feedRun ##1 state_q != ST_ZERO;
  endproperty
  a_zero_stop: assert property (p_zero_stop)
    else $error("return to zero did not stop at zero");

endmodule // orc_homing_setup

// ==== rtl/orc_pkg.sv ====
package orc_pkg;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SETUP = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CNT1 = 8'h0c;
  localparam logic [7:0] ADDR_CNT2 = 8'h10;
  localparam logic [7:0] ADDR_CNT3 = 8'h14;
  localparam logic [7:0] ADDR_CNT4 = 8'h18;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] SETUP_WMASK = 32'hefff_7fff;
  localparam int MODE_LSB = 0;
  localparam int IDX_LSB = 4;
  localparam int MECH_SRC_LSB = 8;
  localparam int DEFL_SRC_LSB = 10;
  localparam int GEN_SRC_LSB = 12;
  localparam int BUSY_GATE_BIT = 14;
  localparam int CLEAR_EN_LSB = 16;
  localparam int HOME_RST_LSB = 20;
  localparam int BACKLASH_LSB = 24;
  localparam int HALT2_BIT = 29;
  localparam int HALT3_BIT = 30;
  localparam int HALT4_BIT = 31;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CNT_W = 32;

  // ---------------------------------------------------------------
  // Homing modes and feed speeds
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_0 = 4'h0;
  localparam logic [3:0] MODE_3 = 4'h3;
  localparam logic [3:0] MODE_5 = 4'h5;
  localparam logic [3:0] MODE_6 = 4'h6;
  localparam logic [3:0] MODE_7 = 4'h7;
  localparam logic [3:0] MODE_8 = 4'h8;
  localparam logic [3:0] MODE_9 = 4'h9;
  localparam logic [3:0] MODE_10 = 4'ha;
  localparam logic [3:0] MODE_11 = 4'hb;
  localparam logic [3:0] MODE_12 = 4'hc;
  localparam logic [1:0] SPEED_NORMAL = 2'h0;
  localparam logic [1:0] SPEED_RFA = 2'h1;
  localparam logic [1:0] SPEED_RFL = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SEEK = 7'h02,
    ST_HALT = 7'h04,
    ST_REVERSE = 7'h08,
    ST_COUNT = 7'h10,
    ST_FINISH = 7'h20,
    ST_ZERO = 7'h40
  } orc_state_t;

  // One count step from a pulse source
  typedef struct packed {
    logic pulse;
    logic up;
  } orc_step_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } orc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } orc_axi_rsp_t;

endpackage

// ==== rtl/orc_step_counter.sv ====
`timescale 1ns/1ns
module orc_step_counter
  import orc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset
  input wire logic clr, // Synchronous clear, wins
  input wire logic en, // Count enable
  input orc_step_t addStep, // Step added with its sign
  input orc_step_t subStep, // Step subtracted with its sign
  output logic [CNT_W-1:0] count // Present count
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] delta;

  // Net change from both step inputs
  always_comb begin
    delta = '0;
    if (addStep.pulse) begin
      delta = addStep.up ? delta + 1'b1 : delta - 1'b1;
    end
    if (subStep.pulse) begin
      delta = subStep.up ? delta - 1'b1 : delta + 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (clr) begin
      count_q <= '0;
    end else if (en) begin
      count_q <= count_q + delta;
    end
  end

  assign count = count_q;

endmodule // orc_step_counter

// ==== tb/orc_axis_model.sv ====
`timescale 1ns/1ns
module orc_axis_model
  import orc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset
  input wire logic feedRun, // Feed command
  input wire logic feedDir, // Feed direction
  output logic motorStopped, // Axis at rest
  output orc_step_t outputPulse // Pulses to driver
);
  logic [1:0] idle_q;
  logic [1:0] div_q;
  // ---------------------------------------------------------------
  // Motor coasts three cycles, steps every fourth cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_q <= 2'h3;
      div_q <= 2'h0;
    end else begin
      idle_q <= feedRun ? 2'h0 : (idle_q == 2'h3 ? idle_q : idle_q + 2'h1);
      div_q <= div_q + 2'h1;
    end
  end
  assign motorStopped = (idle_q == 2'h3);
  assign outputPulse = '{pulse: feedRun && div_q == 2'h0, up: feedDir};
endmodule // orc_axis_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
  import orc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, endLim = 1'b0, idx = 1'b0, bkl = 1'b0;
  logic clrIn = 1'b0, origin_sensor_input = 1'b0, run, dir, stp, dec, done, busyN, stopped;
  logic [1:0] spd;
  logic [31:0] rdv;
  logic [1:0] rsv;
  orc_axi_req_t req = '0;
  orc_axi_rsp_t rsp;
  orc_step_t outP, encP = '0;
  int fails = 0, totalChecks = 0, cyc = 0;
  always #50 clk = ~clk;
  orc_homing_setup i_dut (.clk(clk), .rst(rst), .axiReq(req), .axiRsp(rsp),
    .endLimitInput(endLim), .originSensorInput(origin_sensor_input),
    .encoderIndexInput(idx), .highSpeedFeed(1'b0), .motorStopped(stopped),
    .axisOperating(1'b0), .backlashActive(bkl), .count1Halt(1'b0),
    .counterClearInput(clrIn), .outputPulse(outP), .encoderPhase(encP),
    .pulserPhase(2'h0), .feedRun(run), .feedDir(dir), .feedSpeed(spd),
    .stopNow(stp), .decelStop(dec), .homeDone(done), .motionActiveN(busyN));
  orc_axis_model i_mot (.clk(clk), .rst(rst), .feedRun(run), .feedDir(dir),
    .motorStopped(stopped), .outputPulse(outP));
  // ---------------------------------------------------------------
  // Checking, bus cycles and waits
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hf;
    do @(posedge clk); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0; req.wvalid <= 1'b0; req.bready <= 1'b1;
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    rsv = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    req.arvalid <= 1'b1; req.araddr <= a;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0; req.rready <= 1'b1;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rdv = rsp.rdata; rsv = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic waitFor(ref logic s, input logic v);
    repeat (200) if (s !== v) @(posedge clk);
  endtask
  task automatic step(input int w); // 0 index, 1 encoder, 2 clear
    if (w == 0) idx <= 1'b1;
    else if (w == 1) encP.pulse <= 1'b1;
    else clrIn <= 1'b1;
    @(posedge clk);
    if (w == 0) idx <= 1'b0;
    else if (w == 1) encP.pulse <= 1'b0;
    else clrIn <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_setup();
    rd(ADDR_SETUP); chk("setup reset", SETUP_RESET, rdv);
    wr(ADDR_SETUP, 32'hffff_ffff);
    rd(ADDR_SETUP); chk("reserved bits", SETUP_WMASK, rdv);
    rd(8'h1c); chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsv});
    chk("unmapped data", 32'h0, rdv);
    wr(8'h1c, 32'hffff_ffff);
    chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, rsv});
    wr(ADDR_SETUP, 32'h0);
    $display("test setup done");
  endtask
  task automatic t_home7();
    int n;
    bkl <= 1'b1;
    wr(ADDR_SETUP, 32'h0220_0117);
    wr(ADDR_CTRL, 32'h3);
    waitFor(run, 1'b1); chk("seek dir", 1, dir); chk("busy", 0, busyN);
    repeat (20) @(posedge clk);
    endLim <= 1'b1;
    n = 0;
    while ((stp | dec) !== 1'b1 && n < 10) begin @(posedge clk); n++; end
    chk("limit stop", 1, stp | dec);
    waitFor(run, 1'b1); chk("rev dir", 0, dir);
    chk("rev speed", SPEED_RFA, spd);
    repeat (8) @(posedge clk);
    endLim <= 1'b0; repeat (5) @(posedge clk);
    step(0); chk("early stop", 1, run);
    idx <= 1'b1; @(posedge clk); idx <= 1'b0;
    n = 0;
    while (stp !== 1'b1 && n < 10) begin @(posedge clk); n++; end
    chk("index stop", 1, stp);
    waitFor(done, 1'b1); chk("home done", 1, done);
    rd(ADDR_CNT2); chk("home reset", 32'h0, rdv);
    rd(ADDR_CNT1); chk("backlash gate", 32'h0, rdv);
    bkl <= 1'b0;
    chk("idle busy", 1, busyN);
    $display("test homing mode 7 done");
  endtask
  task automatic t_count();
    wr(ADDR_SETUP, 32'h0003_0000);
    encP.up <= 1'b1;
    repeat (3) step(1);
    rd(ADDR_CNT2); chk("encoder count", 32'h3, rdv);
    bkl <= 1'b1; step(1); bkl <= 1'b0;
    rd(ADDR_CNT2); chk("backlash encoder", 32'h4, rdv);
    wr(ADDR_SETUP, 32'h2003_0000);
    step(1);
    rd(ADDR_CNT2); chk("halted", 32'h4, rdv);
    wr(ADDR_SETUP, 32'h0003_0000);
    step(2);
    rd(ADDR_CNT2); chk("cleared", 32'h0, rdv);
    $display("test counters done");
  endtask
  task automatic t_zero9();
    wr(ADDR_SETUP, 32'h0000_0109);
    wr(ADDR_CTRL, 32'h3);
    repeat (20) @(posedge clk);
    origin_sensor_input <= 1'b1;
    waitFor(run, 1'b0);
    origin_sensor_input <= 1'b0;
    chk("origin stop", 1, stp);
    waitFor(run, 1'b1); chk("zero dir", 0, dir);
    waitFor(done, 1'b1); chk("zero done", 1, done);
    rd(ADDR_CNT2); chk("at zero", 32'h0, rdv);
    $display("test return to zero done");
  endtask
  // ---------------------------------------------------------------
  // Main sequence and timeout
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_setup();
    t_home7();
    t_count();
    t_zero9();
    end_sim();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
endmodule // tb_top
